// [logic/mbp_pkg.sv]
package mbp_pkg;
    // sizes of the timer
    localparam int unsigned MBP_NMATCH = 7;        // match registers 0..6
    localparam int unsigned MBP_NCAP   = 4;        // capture inputs
    localparam int unsigned MBP_NCH    = 6;        // pulse channels 1..6
    localparam int unsigned MBP_MCR_W  = 3;        // match control bits per match
    localparam int unsigned MBP_CCR_W  = 3;        // capture control bits per input
    localparam int unsigned MBP_IR_W   = 11;       // interrupt flag bits
    localparam int unsigned MBP_IR_CAP = 4;        // first capture flag
    localparam int unsigned MBP_IR_HI  = 8;        // flag of match 4

    ////////////////////////////////////////////////////////////////////////////////
    // byte offsets of the register map
    localparam logic [6:0] OFS_IR  = 7'h00;
    localparam logic [6:0] OFS_TCR = 7'h04;
    localparam logic [6:0] OFS_TC  = 7'h08;
    localparam logic [6:0] OFS_PR  = 7'h0c;
    localparam logic [6:0] OFS_PC  = 7'h10;
    localparam logic [6:0] OFS_MCR = 7'h14;
    localparam logic [6:0] OFS_CCR = 7'h28;
    localparam logic [6:0] OFS_PCR = 7'h4c;
    localparam logic [6:0] OFS_LER = 7'h50;
    localparam logic [6:0] OFS_MR [MBP_NMATCH] = '{7'h18, 7'h1c, 7'h20, 7'h24,
                                                   7'h40, 7'h44, 7'h48};
    localparam logic [6:0] OFS_CR [MBP_NCAP]   = '{7'h2c, 7'h30, 7'h34, 7'h38};

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned TCR_EN   = 0;          // counter enable
    localparam int unsigned TCR_RST  = 1;          // counter reset
    localparam int unsigned TCR_PWM  = 3;          // pulse mode enable
    localparam int unsigned MCR_INT  = 0;          // flag on match
    localparam int unsigned MCR_RST  = 1;          // reset counter on match
    localparam int unsigned MCR_STOP = 2;          // stop counter on match
    localparam int unsigned CCR_RISE = 0;          // capture on rising edge
    localparam int unsigned CCR_FALL = 1;          // capture on falling edge
    localparam int unsigned CCR_INT  = 2;          // flag on capture
    localparam int unsigned PCR_EN   = 8;          // enable of channel n at bit 8+n

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [3:0]  RST_TCR  = 4'h0;
    localparam logic [14:0] RST_PCR  = 15'h0;

    // one register bus request
    typedef struct packed {
        logic        read;
        logic        write;
        logic [6:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } mbp_av_req_s;
endpackage

// [logic/mbp_pwm_timer.sv]
`timescale 1ns/100ps
// Overview of operation
// - 32-bit counter behind a 32-bit prescaler
// - counter steps every prescale value plus one
// - seven match registers feed six channels
// - match may flag, reset or stop
// - reset-on-match wraps at end of count
// - match flag rises one clock later
// - stop-on-match clears enable with the flag
// - four captures store count, optionally flag
// - match zero sets the common cycle rate
// - set and clear sources per channel
// - channel one identical in both modes
// - per-channel select bit picks set source
// - single-edge outputs rise at cycle start
// - single-edge falls at match, else stays high
// - double-edge gives positive or negative pulse
// - in pulse mode, match updates wait for software release
// - released values apply at cycle end
// - double-edge value zero acts as rate
// - old value at rate reused once
// - clear wins over simultaneous set
// - value above rate gives no event
// - pulse mode off gives a plain timer
// - latch enable picks released match values
// - output control holds enables and selects
module mbp_pwm_timer (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // register bus
    input  mbp_pkg::mbp_av_req_s     avs_req,
    output logic                     avs_waitrequest,
    output logic [31:0]              avs_readdata,
    // capture inputs
    input  wire logic [3:0]          cap_in,
    // pulse outputs, bit n is pulse_out_n
    output logic [6:1]               pulse_out
);
    import mbp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic                  ack_ff, nxt_ack;             // bus answer cycle
    logic [31:0]           rdata_ff, nxt_rdata;         // read data
    logic [3:0]            tcr_ff, nxt_tcr;             // timer_control_reg
    logic [31:0]           tc_ff, nxt_tc;               // timer_count
    logic [31:0]           pc_ff, nxt_pc;               // prescale counter
    logic [31:0]           pr_ff, nxt_pr;               // prescale_value
    logic                  tick_ff, nxt_tick;           // count changed last edge
    logic [20:0]           mcr_ff, nxt_mcr;             // match control
    logic [31:0]           mr_ff  [MBP_NMATCH];         // written match values
    logic [31:0]           nxt_mr [MBP_NMATCH];
    logic [31:0]           act_ff [MBP_NMATCH];         // match values in use
    logic [31:0]           nxt_act[MBP_NMATCH];
    logic [6:0]            ler_ff, nxt_ler;             // match_latch_enable
    logic [6:0]            pend_ff, nxt_pend;           // one reuse pending
    logic [14:0]           pcr_ff, nxt_pcr;             // output_control
    logic [MBP_IR_W-1:0]   ir_ff, nxt_ir;               // sticky flags
    logic [11:0]           ccr_ff, nxt_ccr;             // capture control
    logic [31:0]           cr_ff  [MBP_NCAP];           // captured counts
    logic [31:0]           nxt_cr [MBP_NCAP];
    logic [3:0]            cap_prev_ff;                 // last capture level
    logic [6:1]            pwm_ff, nxt_pwm;             // channel flip-flops
    logic [6:1]            out_ff, nxt_out;             // gated pin drive

    // combinational helpers
    logic                  req, bus_go, wr_go;
    logic [31:0]           rd_mux;
    logic                  pwm_en, tick_go, wrap, cyc_end, stop_hit;
    logic [31:0]           eff    [MBP_NMATCH];         // value after 0-as-rate
    logic [6:0]            at_match, evt;
    logic [6:1]            set_src, clr_src;
    logic [3:0]            cap_edge;
    logic [31:0]           new_rate;

    // byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction
    // write strobe for one offset, only at the accepting edge
    function automatic logic wr_at(input logic [6:0] ofs, input logic go,
                                   input logic [6:0] adr);
        return go && (adr[6:2] == ofs[6:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the answer
    assign req             = avs_req.read | avs_req.write;
    assign bus_go          = req & ~ack_ff;
    assign wr_go           = avs_req.write & ack_ff;
    assign avs_waitrequest = bus_go;
    assign avs_readdata    = rdata_ff;
    // read mux; unmapped words read zero
    always_comb begin
        rd_mux = RST_WORD;
        case (avs_req.address[6:2])
            OFS_IR[6:2]:  rd_mux = {21'h0, ir_ff};
            OFS_TCR[6:2]: rd_mux = {28'h0, tcr_ff};
            OFS_TC[6:2]:  rd_mux = tc_ff;
            OFS_PR[6:2]:  rd_mux = pr_ff;
            OFS_PC[6:2]:  rd_mux = pc_ff;
            OFS_MCR[6:2]: rd_mux = {11'h0, mcr_ff};
            OFS_CCR[6:2]: rd_mux = {20'h0, ccr_ff};
            OFS_PCR[6:2]: rd_mux = {17'h0, pcr_ff};
            OFS_LER[6:2]: rd_mux = {25'h0, ler_ff};
            default:      rd_mux = RST_WORD;
        endcase
        // match values read back as written, not as in use
        for (int i = 0; i < MBP_NMATCH; i++) begin
            if (avs_req.address[6:2] == OFS_MR[i][6:2]) begin
                rd_mux = mr_ff[i];
            end
        end
        for (int k = 0; k < MBP_NCAP; k++) begin
            if (avs_req.address[6:2] == OFS_CR[k][6:2]) begin
                rd_mux = cr_ff[k];
            end
        end
    end
    // answer timing
    always_comb begin
        nxt_ack   = bus_go;
        nxt_rdata = rdata_ff;
        if (bus_go && avs_req.read) begin
            nxt_rdata = rd_mux;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= RST_WORD;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // match detection
    assign pwm_en = tcr_ff[TCR_PWM];
    always_comb begin
        for (int i = 0; i < MBP_NMATCH; i++) begin
            // zero means the rate in pulse mode
            eff[i] = (pwm_en && i > 0 && act_ff[i] == RST_WORD) ? act_ff[0] : act_ff[i];
            // out-of-range values never match
            at_match[i] = (tc_ff == eff[i]) && (!pwm_en || eff[i] <= act_ff[0]);
            // event in the clock after the count arrives, or a reuse at cycle start
            evt[i] = tick_ff && (at_match[i] || (pend_ff[i] && tc_ff == RST_WORD));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler and counter
    assign tick_go  = tcr_ff[TCR_EN] && !tcr_ff[TCR_RST] && (pc_ff == pr_ff);
    // match zero always wraps in pulse mode
    assign wrap     = (at_match[0] && (mcr_ff[MCR_RST] || pwm_en)) ||
                      (|(at_match & {mcr_ff[19], mcr_ff[16], mcr_ff[13], mcr_ff[10],
                                     mcr_ff[7], mcr_ff[4], mcr_ff[1]}));
    assign cyc_end  = pwm_en && tick_go && at_match[0];
    assign stop_hit = |(evt & {mcr_ff[20], mcr_ff[17], mcr_ff[14], mcr_ff[11],
                               mcr_ff[8], mcr_ff[5], mcr_ff[2]});
    always_comb begin
        nxt_tcr  = tcr_ff;
        nxt_tc   = tc_ff;
        nxt_pc   = pc_ff;
        nxt_pr   = pr_ff;
        nxt_tick = 1'b0;
        if (tcr_ff[TCR_EN] && !tcr_ff[TCR_RST]) begin
            if (tick_go) begin
                nxt_pc   = RST_WORD;
                // the matching count keeps its full prescaled period
                nxt_tc   = wrap ? RST_WORD : tc_ff + 32'h1;
                nxt_tick = 1'b1;
            end else begin
                nxt_pc = pc_ff + 32'h1;
            end
        end
        // held reset keeps both counters at zero
        if (tcr_ff[TCR_RST]) begin
            nxt_tc = RST_WORD;
            nxt_pc = RST_WORD;
        end
        // stop clears the enable together with the flag
        if (stop_hit) begin
            nxt_tcr[TCR_EN] = 1'b0;
        end
        // software writes take priority over counting
        if (wr_at(OFS_TCR, wr_go, avs_req.address)) begin
            nxt_tcr = 4'(merge({28'h0, tcr_ff}, avs_req.writedata, avs_req.byteenable));
        end
        if (wr_at(OFS_TC, wr_go, avs_req.address)) begin
            nxt_tc = merge(tc_ff, avs_req.writedata, avs_req.byteenable);
        end
        if (wr_at(OFS_PC, wr_go, avs_req.address)) begin
            nxt_pc = merge(pc_ff, avs_req.writedata, avs_req.byteenable);
        end
        if (wr_at(OFS_PR, wr_go, avs_req.address)) begin
            nxt_pr = merge(pr_ff, avs_req.writedata, avs_req.byteenable);
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            tcr_ff  <= RST_TCR;
            tc_ff   <= RST_WORD;
            pc_ff   <= RST_WORD;
            pr_ff   <= RST_WORD;
            tick_ff <= 1'b0;
        end else begin
            tcr_ff  <= nxt_tcr;
            tc_ff   <= nxt_tc;
            pc_ff   <= nxt_pc;
            pr_ff   <= nxt_pr;
            tick_ff <= nxt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // match registers, release and shadow transfer
    assign new_rate = ler_ff[0] ? mr_ff[0] : act_ff[0];
    always_comb begin
        nxt_mcr  = mcr_ff;
        nxt_pcr  = pcr_ff;
        nxt_ler  = ler_ff;
        nxt_pend = pend_ff;
        for (int i = 0; i < MBP_NMATCH; i++) begin
            nxt_mr[i]  = mr_ff[i];
            nxt_act[i] = act_ff[i];
            if (wr_at(OFS_MR[i], wr_go, avs_req.address)) begin
                nxt_mr[i] = merge(mr_ff[i], avs_req.writedata, avs_req.byteenable);
            end
            // a reuse fires once, then is gone
            if (evt[i] && tc_ff == RST_WORD) begin
                nxt_pend[i] = 1'b0;
            end
            if (!pwm_en) begin
                // plain timer: values act at once
                nxt_act[i] = nxt_mr[i];
            end else if (cyc_end && ler_ff[i]) begin
                // released values switch only at the wrap
                nxt_act[i] = mr_ff[i];
                nxt_ler[i] = 1'b0;
                if (i > 0 && mr_ff[i] != act_ff[i] && act_ff[i] == act_ff[0] &&
                    act_ff[i] != RST_WORD && mr_ff[i] != RST_WORD &&
                    mr_ff[i] != new_rate) begin
                    nxt_pend[i] = 1'b1;
                end
            end
        end
        if (wr_at(OFS_MCR, wr_go, avs_req.address)) begin
            nxt_mcr = 21'(merge({11'h0, mcr_ff}, avs_req.writedata, avs_req.byteenable));
        end
        if (wr_at(OFS_PCR, wr_go, avs_req.address)) begin
            nxt_pcr = 15'(merge({17'h0, pcr_ff}, avs_req.writedata, avs_req.byteenable));
        end
        // a release written in the wrap cycle is kept
        if (wr_at(OFS_LER, wr_go, avs_req.address)) begin
            nxt_ler = 7'(merge({25'h0, ler_ff}, avs_req.writedata, avs_req.byteenable));
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            mcr_ff  <= 21'h0;
            pcr_ff  <= RST_PCR;
            ler_ff  <= 7'h0;
            pend_ff <= 7'h0;
            for (int i = 0; i < MBP_NMATCH; i++) begin
                mr_ff[i]  <= RST_WORD;
                act_ff[i] <= RST_WORD;
            end
        end else begin
            mcr_ff  <= nxt_mcr;
            pcr_ff  <= nxt_pcr;
            ler_ff  <= nxt_ler;
            pend_ff <= nxt_pend;
            for (int i = 0; i < MBP_NMATCH; i++) begin
                mr_ff[i]  <= nxt_mr[i];
                act_ff[i] <= nxt_act[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture inputs and sticky flags
    always_comb begin
        nxt_ccr = ccr_ff;
        nxt_ir  = ir_ff;
        for (int k = 0; k < MBP_NCAP; k++) begin
            cap_edge[k] = (ccr_ff[k*3+CCR_RISE] && !cap_prev_ff[k] && cap_in[k]) ||
                          (ccr_ff[k*3+CCR_FALL] && cap_prev_ff[k] && !cap_in[k]);
            nxt_cr[k] = cap_edge[k] ? tc_ff : cr_ff[k];
        end
        if (wr_at(OFS_CCR, wr_go, avs_req.address)) begin
            nxt_ccr = 12'(merge({20'h0, ccr_ff}, avs_req.writedata, avs_req.byteenable));
        end
        // write one to clear
        if (wr_at(OFS_IR, wr_go, avs_req.address)) begin
            nxt_ir = ir_ff & ~MBP_IR_W'(merge(RST_WORD, avs_req.writedata,
                                              avs_req.byteenable));
        end
        // a new event beats a clear in the same cycle
        for (int i = 0; i < MBP_NMATCH; i++) begin
            if (evt[i] && mcr_ff[i*3+MCR_INT]) begin
                nxt_ir[i < 4 ? i : i + 4] = 1'b1;
            end
        end
        for (int k = 0; k < MBP_NCAP; k++) begin
            if (cap_edge[k] && ccr_ff[k*3+CCR_INT]) begin
                nxt_ir[MBP_IR_CAP+k] = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ccr_ff      <= 12'h0;
            ir_ff       <= 11'h0;
            cap_prev_ff <= 4'h0;
            for (int k = 0; k < MBP_NCAP; k++) begin
                cr_ff[k] <= RST_WORD;
            end
        end else begin
            ccr_ff      <= nxt_ccr;
            ir_ff       <= nxt_ir;
            cap_prev_ff <= cap_in;
            for (int k = 0; k < MBP_NCAP; k++) begin
                cr_ff[k] <= nxt_cr[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel set and clear sources: select bit n picks match n-1 over match 0
    for (genvar n = 1; n <= MBP_NCH; n++) begin : g_ch
        assign set_src[n] = pcr_ff[n] ? evt[n-1] : evt[0];
        assign clr_src[n] = evt[n];
    end

    // flip-flops move only in pulse mode; disabled pins drive low
    always_comb begin
        nxt_pwm = pwm_ff;
        for (int n = 1; n <= MBP_NCH; n++) begin
            if (pwm_en) begin
                if (clr_src[n]) begin
                    nxt_pwm[n] = 1'b0;
                end else if (set_src[n]) begin
                    nxt_pwm[n] = 1'b1;
                end
            end
        end
        nxt_out = nxt_pwm & pcr_ff[PCR_EN+MBP_NCH:PCR_EN+1];
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_ff <= 6'h0;
            out_ff <= 6'h0;
        end else begin
            pwm_ff <= nxt_pwm;
            out_ff <= nxt_out;
        end
    end
    assign pulse_out = out_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_match_flag_set: assert property (evt[0] && mcr_ff[MCR_INT] |=> ir_ff[0])
        else $error("match flag not raised");
    a_stop_clears_en: assert property (stop_hit && !wr_at(OFS_TCR, wr_go, avs_req.address)
        |=> !tcr_ff[TCR_EN])
        else $error("stop did not clear enable");
    a_wrap_to_zero: assert property (tick_go && wrap && !wr_go |=> ~|tc_ff && tick_ff)
        else $error("counter did not wrap");
    a_prescale_step: assert property (tcr_ff[TCR_EN] && !tcr_ff[TCR_RST] && pc_ff != pr_ff
        && !wr_go |=> tc_ff == $past(tc_ff) && pc_ff == $past(pc_ff) + 32'h1)
        else $error("prescaler step wrong");
    a_clear_wins: assert property (pwm_en && clr_src[2] |=> !pwm_ff[2])
        else $error("clear did not win");
    a_ch1_by_m0: assert property (pwm_en && evt[0] && !evt[1] |=> pwm_ff[1])
        else $error("channel one not set by match zero");
    a_se_rise: assert property (pwm_en && !pcr_ff[3] && evt[0] && !evt[3] |=> pwm_ff[3])
        else $error("single-edge output did not rise");
    a_latch_apply: assert property (cyc_end && ler_ff[1] |=> act_ff[1] == $past(mr_ff[1]))
        else $error("released value not applied");
    a_hold_unrel: assert property (pwm_en && $past(pwm_en) && !$past(ler_ff[2])
        |-> act_ff[2] == $past(act_ff[2]))
        else $error("unreleased value took effect");
    a_capture_load: assert property (cap_edge[0] |=> cr_ff[0] == $past(tc_ff))
        else $error("capture did not load count");
    c_pwm_wrap:    cover property (cyc_end ##1 evt[0]);
    c_capture:     cover property (cap_edge[1] && ccr_ff[3+CCR_INT]);
    c_reuse_fire:  cover property (evt[2] && pend_ff[2]);
    c_stop_match:  cover property (stop_hit ##1 !tcr_ff[TCR_EN]);
endmodule

// [verif/match_based_pwm_timer_bench.sv]
`timescale 1ns/100ps
module match_based_pwm_timer_bench;
    import mbp_pkg::*;
    logic                mclk = 1'b0;     // 25 MHz
    logic                rst  = 1'b1;
    mbp_av_req_s         req  = '0;       // bus request
    logic                avs_waitrequest;
    logic [31:0]         avs_readdata;
    logic [3:0]          cap_in = 4'h0;
    logic [6:1]          pulse_out;
    logic                clr  = 1'b0;
    logic                meas = 1'b0;
    logic [15:0]         hi_cnt [1:6];
    int                  n_errors = 0;
    int                  check_count = 0;
    int                  cyc = 0;
    logic [31:0]         q;

    always #20 mclk = ~mclk;

    mbp_pwm_timer dut (.mclk(mclk), .rst(rst), .avs_req(req),
        .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .cap_in(cap_in), .pulse_out(pulse_out));
    mbp_load load (.mclk(mclk), .clr(clr), .meas(meas), .pulse_out(pulse_out),
        .hi_cnt(hi_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus cycle held until waitrequest is seen low, then a free edge
    task automatic bus(input logic rd, input logic [6:0] a, input logic [31:0] d);
        req.read      <= rd;
        req.write     <= ~rd;
        req.address   <= a;
        req.byteenable <= 4'hf;
        req.writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge mclk);
    endtask

    // 20-cycle window, two whole periods at rate 9 and prescale 0
    task automatic window();
        clr  <= 1'b1;
        @(posedge mclk);
        clr  <= 1'b0;
        meas <= 1'b1;
        repeat (20) @(posedge mclk);
        meas <= 1'b0;
        @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset leaves registers zero and pins low
    task automatic t_reset();
        bus(1'b1, OFS_TCR, 32'h0);
        chk("tcr", q, 32'h0);
        bus(1'b1, OFS_MR[1], 32'h0);
        chk("mr1", q, 32'h0);
        chk("pins", 32'(pulse_out), 32'h0);
        bus(1'b1, 7'h7c, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask

    // prescale 2, match 6, stop and flag on match
    task automatic t_stop();
        bus(1'b0, OFS_PR, 32'h2);
        bus(1'b0, OFS_MR[0], 32'h6);
        bus(1'b0, OFS_MCR, 32'h5);
        bus(1'b0, OFS_TCR, 32'h1);
        repeat (30) @(posedge mclk);
        bus(1'b1, OFS_TCR, 32'h0);
        chk("tcr stop", q, 32'h0);
        bus(1'b1, OFS_TC, 32'h0);
        chk("tc stop", q, 32'h6);
        bus(1'b1, OFS_IR, 32'h0);
        chk("ir flag", q, 32'h1);
        bus(1'b0, OFS_IR, 32'h1);
        bus(1'b1, OFS_IR, 32'h0);
        chk("ir clear", q, 32'h0);
    endtask

    // mixed single and double edge channels at rate 9
    task automatic t_pwm();
        logic [15:0] exp [1:6];
        exp = '{16'd10, 16'd0, 16'd6, 16'd10, 16'd16, 16'd12};
        bus(1'b0, OFS_TCR, 32'h2);
        bus(1'b0, OFS_MCR, 32'h0);
        bus(1'b0, OFS_PR, 32'h0);
        bus(1'b0, OFS_MR[0], 32'h9);
        bus(1'b0, OFS_MR[1], 32'h4);
        bus(1'b0, OFS_MR[2], 32'h0);
        bus(1'b0, OFS_MR[3], 32'h2);
        bus(1'b0, OFS_MR[4], 32'h7);
        bus(1'b0, OFS_MR[5], 32'h7);
        bus(1'b0, OFS_MR[6], 32'h3);
        bus(1'b0, OFS_PCR, 32'h7e50);
        bus(1'b0, OFS_LER, 32'h7f);
        bus(1'b0, OFS_TCR, 32'h9);
        repeat (15) @(posedge mclk);
        window();
        for (int n = 1; n <= 6; n++) begin
            chk($sformatf("high ch%0d", n), 32'(hi_cnt[n]), 32'(exp[n]));
        end
        // value above rate held back until released
        bus(1'b0, OFS_MR[1], 32'hc);
        window();
        chk("ch1 unreleased", 32'(hi_cnt[1]), 32'd10);
        bus(1'b0, OFS_LER, 32'h2);
        repeat (12) @(posedge mclk);
        window();
        chk("ch1 released", 32'(hi_cnt[1]), 32'd20);
    endtask

    // halted counter at a known count, rising edge on input 0 with flag
    task automatic t_capture();
        bus(1'b0, OFS_TCR, 32'h0);
        bus(1'b0, OFS_TC, 32'h55);
        bus(1'b0, OFS_CCR, 32'h5);
        cap_in <= 4'h1;
        repeat (2) @(posedge mclk);
        bus(1'b1, OFS_CR[0], 32'h0);
        chk("cr0 capture", q, 32'h55);
        bus(1'b1, OFS_IR, 32'h0);
        chk("ir capture", q, 32'h10);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_stop();
        t_pwm();
        t_capture();
        tally_and_finish();
    end
endmodule

// [verif/mbp_load.sv]
`timescale 1ns/100ps
// load on the pulse pins: counts high cycles of each channel in a window
module mbp_load (
    // clock and window control
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic        meas,
    // pins from the timer
    input  wire logic [6:1]  pulse_out,
    // high-cycle counts per channel
    output logic [15:0]      hi_cnt [1:6]
);
    ////////////////////////////////////////////////////////////////////////////////
    // counts hold while the window is closed so the bench reads them calmly
    always_ff @(posedge mclk) begin
        for (int n = 1; n <= 6; n++) begin
            if (clr) begin
                hi_cnt[n] <= 16'h0;
            end else if (meas) begin
                hi_cnt[n] <= hi_cnt[n] + 16'(pulse_out[n]);
            end
        end
    end
endmodule
